// ===== inc/mcam_pkg.sv
package mcam_pkg;

	// register offsets on the internal register port
	localparam logic [7:0] MCAM_ADDR_CONFIG_TWO = 8'h73;
	localparam logic [7:0] MCAM_ADDR_MASK_ONE   = 8'h74;
	localparam logic [7:0] MCAM_ADDR_MASK_TWO   = 8'h75;

	// reset values, unmapped read value and shutdown duty readback value
	localparam logic [7:0] MCAM_RST_CONFIG_TWO = 8'h00;
	localparam logic [7:0] MCAM_RST_MASK_ONE   = 8'h00;
	localparam logic [7:0] MCAM_RST_MASK_TWO   = 8'h00;
	localparam logic [7:0] MCAM_RD_UNMAPPED    = 8'h00;
	localparam logic [7:0] MCAM_DUTY_OFF       = 8'h00;

	// configuration register two fields
	localparam int MCAM_CFG_TWO_WIRE_LSB = 0;
	localparam int MCAM_CFG_AVG_OFF      = 4;
	localparam int MCAM_CFG_ATTENUATOR_BYPASS_BYPASS  = 5;
	localparam int MCAM_CFG_SINGLE_CH    = 6;
	localparam int MCAM_CFG_SHUTDOWN     = 7;

	// mask register one fields
	localparam int MCAM_M1_V25  = 0;
	localparam int MCAM_M1_CORE = 1;
	localparam int MCAM_M1_VCC  = 2;
	localparam int MCAM_M1_V5   = 3;
	localparam int MCAM_M1_R1T  = 4;
	localparam int MCAM_M1_LT   = 5;
	localparam int MCAM_M1_R2T  = 6;
	localparam int MCAM_M1_ALL2 = 7;

	// mask register two fields
	localparam int MCAM_M2_V12  = 0;
	localparam int MCAM_M2_OVT  = 1;
	localparam int MCAM_M2_FIRST_FAN_FAULT_MASK = 2;
	localparam int MCAM_M2_SECOND_FAN_FAULT_MASK = 3;
	localparam int MCAM_M2_THIRD_FAN_FAULT_MASK = 4;
	localparam int MCAM_M2_F4P  = 5;
	localparam int MCAM_M2_D1   = 6;
	localparam int MCAM_M2_D2   = 7;

	// bits of mask two that software may change (thermal pin mask is fixed)
	localparam logic [7:0] MCAM_M2_WR_MASK = 8'hfd;

	// fan and pwm geometry
	localparam int MCAM_NUM_FANS  = 4;
	localparam int MCAM_ALERT_PWM = 1; // pwm pin shared with the alert

	// single-channel conversion channel codes
	typedef enum logic [2:0] {
		MCAM_CH_V25   = 3'b000,
		MCAM_CH_CORE  = 3'b001,
		MCAM_CH_VCC   = 3'b010,
		MCAM_CH_V5    = 3'b011,
		MCAM_CH_V12   = 3'b100,
		MCAM_CH_R1T   = 3'b101,
		MCAM_CH_LOCAL = 3'b110,
		MCAM_CH_R2T   = 3'b111
	} mcam_chan_t;

	// out-of-limit and fault conditions offered to the alert
	typedef struct packed {
		logic v25;
		logic core;
		logic vcc;
		logic v5;
		logic r1t;
		logic lt;
		logic r2t;
		logic v12;
		logic overtemp_pin_mask;
		logic first_fan_fault_mask;
		logic second_fan_fault_mask;
		logic third_fan_fault_mask;
		logic fan4;
		logic thermal_signal_pin_timer;
		logic d1;
		logic d2;
	} mcam_cond_t;

endpackage : mcam_pkg

// ===== design/mcam_alert_gate.sv
`timescale 1ns/1ps
module mcam_alert_gate
	import mcam_pkg::*;
(
	input  wire mcam_cond_t  i_cond,          // live conditions
	input  wire logic [7:0]  i_mask_one,      // mask register one
	input  wire logic [7:0]  i_mask_two,      // mask register two
	input  wire logic        i_fourth_is_thermal, // speed input 4 is thermal
	output logic             o_any            // any unmasked condition
);
	logic grp_one;
	logic grp_two;
	logic fourth_evt;

	// fourth bit guards the fan 4 fault or the thermal timer event
	assign fourth_evt = i_fourth_is_thermal ? i_cond.thermal_signal_pin_timer
	                                        : i_cond.fan4;

	// status one group
	assign grp_one = (i_cond.v25  & ~i_mask_one[MCAM_M1_V25])
	               | (i_cond.core & ~i_mask_one[MCAM_M1_CORE])
	               | (i_cond.vcc  & ~i_mask_one[MCAM_M1_VCC])
	               | (i_cond.v5   & ~i_mask_one[MCAM_M1_V5])
	               | (i_cond.r1t  & ~i_mask_one[MCAM_M1_R1T])
	               | (i_cond.lt   & ~i_mask_one[MCAM_M1_LT])
	               | (i_cond.r2t  & ~i_mask_one[MCAM_M1_R2T]);

	// status two group, blocked as a whole by the group mask
	assign grp_two = ~i_mask_one[MCAM_M1_ALL2] & (
	                 (i_cond.v12  & ~i_mask_two[MCAM_M2_V12])
	               | (i_cond.overtemp_pin_mask  & ~i_mask_two[MCAM_M2_OVT])
	               | (i_cond.first_fan_fault_mask & ~i_mask_two[MCAM_M2_FIRST_FAN_FAULT_MASK])
	               | (i_cond.second_fan_fault_mask & ~i_mask_two[MCAM_M2_SECOND_FAN_FAULT_MASK])
	               | (i_cond.third_fan_fault_mask & ~i_mask_two[MCAM_M2_THIRD_FAN_FAULT_MASK])
	               | (fourth_evt  & ~i_mask_two[MCAM_M2_F4P])
	               | (i_cond.d1   & ~i_mask_two[MCAM_M2_D1])
	               | (i_cond.d2   & ~i_mask_two[MCAM_M2_D2]));

	assign o_any = grp_one | grp_two;

endmodule : mcam_alert_gate

// ===== design/mcam_config_alert.sv
`timescale 1ns/1ps
// Operation
// - config bits 0-3 pick two-wire fan sensing
// - config bit 4 turns averaging off
// - config bit 5 bypasses input attenuators
// - config bit 6 selects single-channel conversion
// - channel code taken from 0x55 bits 7:5
// - test bit 2 starts conversions from external clock
// - config bit 7 shuts down, pwm at off level
// - duty readback shows 0x00 while shut down
// - lock bit makes config two read-only
// - mask one bits 0-3 block voltage alerts
// - mask one bits 4-6 block temperature alerts
// - mask one bit 7 blocks status two alerts
// - mask two bit 0 blocks 12 V alert
// - mask two bit 1 read-only, thermal pin
// - mask two bits 2-4 block fan 1-3 faults
// - mask two bit 5 fan 4 or timer
// - mask two bits 6-7 block diode faults
// - reset clears config two and both masks
// - alert pin only with config three bit 0
module mcam_config_alert
	import mcam_pkg::*;
(
	input  wire logic        i_sys_clk,           // 40 MHz core clock
	input  wire logic        i_sys_rst,           // synchronous reset, high
	// register port from the smbus engine
	input  wire logic [7:0]  i_reg_addr,          // register pointer
	input  wire logic        i_reg_wr,            // write strobe
	input  wire logic [7:0]  i_reg_wdata,         // write data
	input  wire logic        i_reg_rd,            // read strobe
	output logic      [7:0]  o_reg_rdata,         // read data
	output logic             o_reg_rvalid,        // read data valid pulse
	// settings held elsewhere in the register map
	input  wire logic        i_config_lock,       // config one lock bit
	input  wire logic        i_pwm_polarity_flip, // pwm invert setting
	input  wire logic        i_alert_pin_enable,  // config three bit 0
	input  wire logic [7:0]  i_tach1_min_high,    // register 0x55
	input  wire logic        i_ext_single_channel_mode_enable,   // test two bit 2
	input  wire logic        i_fourth_is_thermal, // speed input 4 thermal
	// conversion and fan datapath
	input  wire logic        i_ext_single_channel_mode_clk,      // external start clock
	input  wire logic        i_single_channel_mode_done,         // adc finished one
	input  wire logic [3:0]  i_pwm_raw,           // pwm from fan control
	input  wire logic [31:0] i_duty_raw,          // duty per fan, 8 bits
	input  wire mcam_cond_t  i_cond,              // live conditions
	output logic [3:0]       o_fan_two_wire_sel,  // two-wire sensing
	output logic             o_averaging_disable, // averaging off
	output logic             o_attenuator_bypass, // attenuators bypassed
	output logic             o_single_channel_mode, // single channel
	output logic             o_shutdown_select,   // device shut down
	output logic [2:0]       o_single_channel_mode_channel,      // selected channel
	output logic             o_single_channel_mode_start,        // start conversion pulse
	output logic [31:0]      o_duty_readback,     // duty as software sees
	output logic [3:0]       o_pwm,               // pwm pin levels
	output logic             o_pwm_alert_oe_n,    // shared pin enable, low
	output logic             o_alert_active       // alert asserted
);

	// all state of the block
	typedef struct packed {
		logic [7:0]                       cfg2;
		logic [7:0]                       mask1;
		logic [7:0]                       mask2;
		logic [7:0]                       rdata;
		logic                             rvalid;
		logic [MCAM_NUM_FANS-1:0][7:0]    duty_rb;
		logic [MCAM_NUM_FANS-1:0]         pwm;
		logic                             pwm_oe_n;
		logic                             alert;
		logic                             ext_clk_q;
		logic                             single_channel_mode_start;
		mcam_chan_t                       chan;
	} mcam_state_t;

	mcam_state_t st;
	mcam_state_t next_st;

	logic                          alert_any;
	logic                          shut;
	logic                          single;
	logic                          ext_rise;
	logic [MCAM_NUM_FANS-1:0][7:0] duty_in;
	logic [MCAM_NUM_FANS-1:0]      pwm_drive;

	// condition gating against the two mask registers
	mcam_alert_gate u_gate (
		.i_cond              (i_cond),
		.i_mask_one          (st.mask1),
		.i_mask_two          (st.mask2),
		.i_fourth_is_thermal (i_fourth_is_thermal),
		.o_any               (alert_any)
	);

	// decoded mode bits
	assign shut   = st.cfg2[MCAM_CFG_SHUTDOWN];
	assign single = st.cfg2[MCAM_CFG_SINGLE_CH];
	assign duty_in = i_duty_raw;

	// rising edge of the external start clock, input is synchronous
	assign ext_rise = i_ext_single_channel_mode_clk & ~st.ext_clk_q;

	// per-fan pwm level, polarity setting while shut down
	genvar g;
	generate
		for (g = 0; g < MCAM_NUM_FANS; g++) begin : g_fan
			assign pwm_drive[g] = shut ? i_pwm_polarity_flip
			                           : i_pwm_raw[g];
		end
	endgenerate

	// next-state logic
	always_comb begin
		next_st = st;

		// register writes
		if (i_reg_wr) begin
			case (i_reg_addr)
				MCAM_ADDR_CONFIG_TWO: begin
					if (!i_config_lock) begin
						next_st.cfg2 = i_reg_wdata;
					end
				end
				MCAM_ADDR_MASK_ONE: begin
					next_st.mask1 = i_reg_wdata;
				end
				MCAM_ADDR_MASK_TWO: begin
					// thermal pin mask keeps its value
					next_st.mask2 = (i_reg_wdata & MCAM_M2_WR_MASK)
					              | (st.mask2 & ~MCAM_M2_WR_MASK);
				end
				default: begin
					next_st.mask2 = st.mask2; // other offsets not ours
				end
			endcase
		end

		// register reads, answered one cycle after the strobe
		next_st.rvalid = i_reg_rd;
		if (i_reg_rd) begin
			case (i_reg_addr)
				MCAM_ADDR_CONFIG_TWO: next_st.rdata = st.cfg2;
				MCAM_ADDR_MASK_ONE:   next_st.rdata = st.mask1;
				MCAM_ADDR_MASK_TWO:   next_st.rdata = st.mask2;
				default:              next_st.rdata = MCAM_RD_UNMAPPED;
			endcase
		end

		// duty readback forced to zero while shut down
		for (int i = 0; i < MCAM_NUM_FANS; i++) begin
			next_st.duty_rb[i] = shut ? MCAM_DUTY_OFF : duty_in[i];
		end

		// channel for single-channel conversions
		next_st.chan = mcam_chan_t'(i_tach1_min_high[7:5]);

		// conversion start in single-channel mode
		next_st.ext_clk_q  = i_ext_single_channel_mode_clk;
		next_st.single_channel_mode_start = 1'b0;
		if (single && !shut) begin
			if (i_ext_single_channel_mode_enable) begin
				next_st.single_channel_mode_start = ext_rise;
			end else begin
				next_st.single_channel_mode_start = i_single_channel_mode_done;
			end
		end

		// alert only on an unmasked condition and an enabled pin
		next_st.alert = alert_any & i_alert_pin_enable;

		// pwm pins; shared pin becomes open-drain alert when enabled
		next_st.pwm      = pwm_drive;
		next_st.pwm_oe_n = 1'b0;
		if (i_alert_pin_enable) begin
			next_st.pwm[MCAM_ALERT_PWM] = 1'b0;
			next_st.pwm_oe_n            = ~next_st.alert; // pull low
		end
	end

	// state register
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			st            <= '0;
			st.cfg2       <= MCAM_RST_CONFIG_TWO;
			st.mask1      <= MCAM_RST_MASK_ONE;
			st.mask2      <= MCAM_RST_MASK_TWO;
			st.rdata      <= MCAM_RD_UNMAPPED;
			st.chan       <= MCAM_CH_V25;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign o_reg_rdata           = st.rdata;
	assign o_reg_rvalid          = st.rvalid;
	assign o_fan_two_wire_sel    = st.cfg2[MCAM_CFG_TWO_WIRE_LSB +: 4];
	assign o_averaging_disable   = st.cfg2[MCAM_CFG_AVG_OFF];
	assign o_attenuator_bypass   = st.cfg2[MCAM_CFG_ATTENUATOR_BYPASS_BYPASS];
	assign o_single_channel_mode = st.cfg2[MCAM_CFG_SINGLE_CH];
	assign o_shutdown_select     = st.cfg2[MCAM_CFG_SHUTDOWN];
	assign o_single_channel_mode_channel        = st.chan;
	assign o_single_channel_mode_start          = st.single_channel_mode_start;
	assign o_duty_readback       = st.duty_rb;
	assign o_pwm                 = st.pwm;
	assign o_pwm_alert_oe_n      = st.pwm_oe_n;
	assign o_alert_active        = st.alert;

endmodule : mcam_config_alert

// ===== dv/mcam_checker.sv
`timescale 1ns/1ps
// port-level checks of the config and alert mask bank
module mcam_checker
	import mcam_pkg::*;
(
	input wire logic        i_sys_clk,             // clock
	input wire logic        i_sys_rst,             // reset
	input wire logic [7:0]  i_reg_addr,            // pointer
	input wire logic        i_reg_wr,              // write
	input wire logic [7:0]  i_reg_wdata,           // data
	input wire logic        i_config_lock,         // lock
	input wire logic        i_pwm_polarity_flip,   // invert
	input wire logic        i_alert_pin_enable,    // alert pin
	input wire logic [7:0]  i_tach1_min_high,      // channel code
	input wire logic        i_ext_single_channel_mode_enable,     // ext start
	input wire logic        i_ext_single_channel_mode_clk,        // ext clock
	input wire logic [31:0] i_duty_raw,            // duty in
	input wire mcam_cond_t  i_cond,                // conditions
	input wire logic [3:0]  o_fan_two_wire_sel,    // cfg 3:0
	input wire logic        o_averaging_disable,   // cfg 4
	input wire logic        o_attenuator_bypass,   // cfg 5
	input wire logic        o_single_channel_mode, // cfg 6
	input wire logic        o_shutdown_select,     // cfg 7
	input wire logic [2:0]  o_single_channel_mode_channel,        // channel
	input wire logic        o_single_channel_mode_start,          // start
	input wire logic [31:0] o_duty_readback,       // duty out
	input wire logic [3:0]  o_pwm,                 // pwm pins
	input wire logic        o_pwm_alert_oe_n,      // shared enable
	input wire logic        o_alert_active         // alert
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	// config two as one byte
	wire [7:0] cfg = {o_shutdown_select, o_single_channel_mode,
		o_attenuator_bypass, o_averaging_disable, o_fan_two_wire_sel};
	wire cfg_wr = i_reg_wr && i_reg_addr == 8'h73;
	a_cfg_write: assert property (
		cfg_wr && !i_config_lock |=> cfg == $past(i_reg_wdata))
		else $error("config write not taken");
	a_cfg_locked: assert property (cfg_wr && i_config_lock |=> $stable(cfg))
		else $error("locked config changed");
	a_shutdown_select_pwm: assert property (
		o_shutdown_select |=> o_pwm[0] == $past(i_pwm_polarity_flip))
		else $error("pwm not at off level");
	a_duty_off: assert property (o_shutdown_select |=> o_duty_readback == 0)
		else $error("duty not zero in shutdown");
	a_duty_pass: assert property (
		!o_shutdown_select |=> o_duty_readback == $past(i_duty_raw))
		else $error("duty not passed");
	a_chan_follow: assert property (
		1'b1 |=> o_single_channel_mode_channel == $past(i_tach1_min_high[7:5]))
		else $error("channel not taken");
	a_ext_start: assert property (
		i_ext_single_channel_mode_enable && o_single_channel_mode && !o_shutdown_select
		&& $rose(i_ext_single_channel_mode_clk) |=> o_single_channel_mode_start)
		else $error("no start on external clock");
	a_start_idle: assert property (!o_single_channel_mode |=> !o_single_channel_mode_start)
		else $error("start outside single mode");
	a_alert_off: assert property (!i_alert_pin_enable |=> !o_alert_active)
		else $error("alert without pin");
	a_alert_quiet: assert property (i_cond == '0 |=> !o_alert_active)
		else $error("alert without cause");
	a_alert_oe: assert property (
		o_alert_active |-> !o_pwm_alert_oe_n && !o_pwm[1])
		else $error("alert pin not driven");
	// main scenarios reached
	c_alert: cover property (o_alert_active);
	c_start: cover property (o_single_channel_mode_start);
	c_shutdown_select: cover property (o_shutdown_select);
endmodule : mcam_checker

bind mcam_config_alert mcam_checker u_mcam_checker (.i_sys_clk, .i_sys_rst,
	.i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_config_lock, .i_pwm_polarity_flip,
	.i_alert_pin_enable, .i_tach1_min_high, .i_ext_single_channel_mode_enable, .i_ext_single_channel_mode_clk,
	.i_duty_raw, .i_cond, .o_fan_two_wire_sel, .o_averaging_disable,
	.o_attenuator_bypass, .o_single_channel_mode, .o_shutdown_select,
	.o_single_channel_mode_channel, .o_single_channel_mode_start, .o_duty_readback, .o_pwm,
	.o_pwm_alert_oe_n, .o_alert_active);

// ===== dv/mcam_host_model.sv
`timescale 1ns/1ps
// host side of the byte register port
module mcam_host_model (
	input  wire logic       i_sys_clk,   // clock
	output logic      [7:0] o_reg_addr,  // pointer
	output logic            o_reg_wr,    // write strobe
	output logic      [7:0] o_reg_wdata, // write data
	output logic            o_reg_rd,    // read strobe
	input  wire logic [7:0] i_reg_rdata, // read data
	input  wire logic       i_reg_rvalid // read valid
);
	// idle bus at time zero
	initial begin
		{o_reg_addr, o_reg_wdata, o_reg_wr, o_reg_rd} = '0;
	end
	// one write; released lines show the inverse value
	// each transfer starts just after an edge, so back to back calls
	// never lower and raise a strobe in the same time step
	task wr(input logic [7:0] a, d);
		@(posedge i_sys_clk);
		#1;
		o_reg_addr = a;
		o_reg_wdata = d;
		o_reg_wr = 1'b1;
		@(posedge i_sys_clk);
		#1;
		o_reg_wr = 1'b0;
		o_reg_addr = ~a;
		o_reg_wdata = ~d;
	endtask : wr
	// one read; answer taken the cycle after the strobe
	task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge i_sys_clk);
		#1;
		o_reg_addr = a;
		o_reg_rd = 1'b1;
		@(posedge i_sys_clk);
		#1;
		o_reg_rd = 1'b0;
		o_reg_addr = ~a;
		d = i_reg_rdata;
		v = i_reg_rvalid;
	endtask : rd
endmodule : mcam_host_model

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb
	import mcam_pkg::*;
;
	logic        i_sys_clk = 1'b0, i_sys_rst = 1'b1;
	logic        i_config_lock = 1'b0, i_pwm_polarity_flip = 1'b0;
	logic        i_alert_pin_enable = 1'b0, i_ext_single_channel_mode_enable = 1'b0;
	logic        i_fourth_is_thermal = 1'b0, i_ext_single_channel_mode_clk = 1'b0;
	logic        i_single_channel_mode_done = 1'b0, i_reg_wr, i_reg_rd, o_reg_rvalid;
	logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata;
	logic [7:0]  i_tach1_min_high = 8'h00;
	logic [3:0]  i_pwm_raw = 4'h0, o_fan_two_wire_sel, o_pwm;
	logic [31:0] i_duty_raw = 32'h0, o_duty_readback;
	mcam_cond_t  i_cond = '0;
	logic        o_averaging_disable, o_attenuator_bypass, o_shutdown_select;
	logic        o_single_channel_mode, o_single_channel_mode_start, o_pwm_alert_oe_n;
	logic        o_alert_active;
	logic [2:0]  o_single_channel_mode_channel;
	int          err_total = 0, checked = 0, cyc = 0;
	// device under test and host
	mcam_config_alert u_mcam_config_alert (.i_sys_clk, .i_sys_rst, .i_reg_addr,
		.i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
		.i_config_lock, .i_pwm_polarity_flip, .i_alert_pin_enable,
		.i_tach1_min_high, .i_ext_single_channel_mode_enable, .i_fourth_is_thermal,
		.i_ext_single_channel_mode_clk, .i_single_channel_mode_done, .i_pwm_raw, .i_duty_raw, .i_cond,
		.o_fan_two_wire_sel, .o_averaging_disable, .o_attenuator_bypass,
		.o_single_channel_mode, .o_shutdown_select, .o_single_channel_mode_channel,
		.o_single_channel_mode_start, .o_duty_readback, .o_pwm, .o_pwm_alert_oe_n,
		.o_alert_active);
	mcam_host_model u_mcam_host_model (.i_sys_clk, .o_reg_addr(i_reg_addr),
		.o_reg_wr(i_reg_wr), .o_reg_wdata(i_reg_wdata), .o_reg_rd(i_reg_rd),
		.i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid));
	// 40 MHz clock and hang guard
	always #12.5 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			stop_test();
		end
	end
	task stop_test;
		if (err_total == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task step(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : step
	task chk(input string n, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task rdc(input logic [7:0] a, e);
		logic [7:0] d;
		logic       v;
		u_mcam_host_model.rd(a, d, v);
		chk("rvalid", 32'h1, 32'(v));
		chk("rdata", 32'(e), 32'(d));
	endtask : rdc
	task t_reset;
		rdc(MCAM_ADDR_CONFIG_TWO, MCAM_RST_CONFIG_TWO);
		rdc(MCAM_ADDR_MASK_ONE, MCAM_RST_MASK_ONE);
		rdc(MCAM_ADDR_MASK_TWO, MCAM_RST_MASK_TWO);
		rdc(8'h76, MCAM_RD_UNMAPPED);
	endtask : t_reset
	task t_cfg;
		for (int i = 0; i < 8; i++) begin
			u_mcam_host_model.wr(MCAM_ADDR_CONFIG_TWO, 8'(1 << i));
			chk("cfg", 32'(1 << i), 32'({o_shutdown_select, o_single_channel_mode,
				o_attenuator_bypass, o_averaging_disable, o_fan_two_wire_sel}));
			rdc(MCAM_ADDR_CONFIG_TWO, 8'(1 << i));
		end
		u_mcam_host_model.wr(MCAM_ADDR_CONFIG_TWO, 8'h3c);
		i_config_lock = 1'b1;
		u_mcam_host_model.wr(MCAM_ADDR_CONFIG_TWO, 8'hc3);
		rdc(MCAM_ADDR_CONFIG_TWO, 8'h3c);
		i_config_lock = 1'b0;
	endtask : t_cfg
	task t_shutdown_select;
		i_pwm_polarity_flip = 1'b1;
		i_pwm_raw = 4'ha;
		i_duty_raw = 32'h11223344;
		u_mcam_host_model.wr(MCAM_ADDR_CONFIG_TWO, 8'h80);
		step(1);
		chk("duty", 32'h0, o_duty_readback);
		chk("pwm", 32'hf, 32'(o_pwm));
		i_pwm_polarity_flip = 1'b0;
		step(2);
		chk("pwm", 32'h0, 32'(o_pwm));
		u_mcam_host_model.wr(MCAM_ADDR_CONFIG_TWO, 8'h00);
		step(1);
		chk("duty", 32'h11223344, o_duty_readback);
		chk("pwm run", 32'ha, 32'(o_pwm));
	endtask : t_shutdown_select
	task t_masks;
		logic [7:0] b;
		i_alert_pin_enable = 1'b1;
		for (int j = 0; j < 16; j++) begin
			b = (j > 8) ? 8'(1 << (15 - j)) : 8'(1 << ((j > 2) ? 8 - j : 7 - j));
			i_fourth_is_thermal = (j == 2);
			u_mcam_host_model.wr(MCAM_ADDR_MASK_ONE, 8'h00);
			u_mcam_host_model.wr(MCAM_ADDR_MASK_TWO, 8'h00);
			i_cond = mcam_cond_t'(16'(1 << j));
			step(2);
			chk("alert", 32'h1, 32'(o_alert_active));
			chk("oe_n", 32'h0, 32'(o_pwm_alert_oe_n));
			u_mcam_host_model.wr(j > 8 ? MCAM_ADDR_MASK_ONE : MCAM_ADDR_MASK_TWO, b);
			step(2);
			chk("masked", 32'(j == 7), 32'(o_alert_active));
			chk("oe_n masked", 32'(j != 7), 32'(o_pwm_alert_oe_n));
			if (j <= 8) begin
				u_mcam_host_model.wr(MCAM_ADDR_MASK_TWO, 8'h00);
				u_mcam_host_model.wr(MCAM_ADDR_MASK_ONE, 8'h80);
				step(2);
				chk("status two", 32'h0, 32'(o_alert_active));
			end
		end
		u_mcam_host_model.wr(MCAM_ADDR_MASK_TWO, 8'hff);
		rdc(MCAM_ADDR_MASK_TWO, 8'hfd);
		u_mcam_host_model.wr(MCAM_ADDR_MASK_ONE, 8'h00);
		i_alert_pin_enable = 1'b0;
		step(2);
		chk("alert off", 32'h0, 32'(o_alert_active));
		i_cond = '0;
	endtask : t_masks
	task t_single_channel_mode;
		u_mcam_host_model.wr(MCAM_ADDR_CONFIG_TWO, 8'h40);
		for (int c = 0; c < 8; c++) begin
			i_tach1_min_high = {3'(c), 5'h00};
			step(2);
			chk("channel", 32'(c), 32'(o_single_channel_mode_channel));
		end
		i_ext_single_channel_mode_enable = 1'b1;
		i_ext_single_channel_mode_clk = 1'b1;
		step(1);
		chk("ext start", 32'h1, 32'(o_single_channel_mode_start));
		step(1);
		chk("ext start end", 32'h0, 32'(o_single_channel_mode_start));
		i_ext_single_channel_mode_clk = 1'b0;
		i_ext_single_channel_mode_enable = 1'b0;
		i_single_channel_mode_done = 1'b1;
		step(1);
		i_single_channel_mode_done = 1'b0;
		chk("restart", 32'h1, 32'(o_single_channel_mode_start));
		u_mcam_host_model.wr(MCAM_ADDR_CONFIG_TWO, 8'h00);
		i_single_channel_mode_done = 1'b1;
		step(1);
		i_single_channel_mode_done = 1'b0;
		chk("no start", 32'h0, 32'(o_single_channel_mode_start));
	endtask : t_single_channel_mode
	// reset in mid-run clears written registers again
	task t_rerst;
		u_mcam_host_model.wr(MCAM_ADDR_MASK_ONE, 8'hff);
		u_mcam_host_model.wr(MCAM_ADDR_MASK_TWO, 8'hff);
		u_mcam_host_model.wr(MCAM_ADDR_CONFIG_TWO, 8'h5a);
		i_sys_rst = 1'b1;
		step(2);
		i_sys_rst = 1'b0;
		chk("shutdown rst", 32'h0, 32'(o_shutdown_select));
		rdc(MCAM_ADDR_CONFIG_TWO, MCAM_RST_CONFIG_TWO);
		rdc(MCAM_ADDR_MASK_ONE, MCAM_RST_MASK_ONE);
		rdc(MCAM_ADDR_MASK_TWO, MCAM_RST_MASK_TWO);
	endtask : t_rerst
	// main sequence
	initial begin
		step(8);
		i_sys_rst = 1'b0;
		t_reset();
		t_cfg();
		t_shutdown_select();
		t_masks();
		t_single_channel_mode();
		t_rerst();
		stop_test();
	end
endmodule : tb
